// ===== shared/pbt_cfg.svh
// offsets, field positions, reset values and timing figures of the periodic timebase
`ifndef PBT_CFG_SVH
`define PBT_CFG_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define PBT_ADDR_W          8
`define PBT_DATA_W          8
`define PBT_CTRL_OFS        8'h00

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define PBT_FLAG_BIT        7
`define PBT_RATE_MSB        6
`define PBT_RATE_LSB        4
`define PBT_ACK_BIT         3
`define PBT_IRQ_EN_BIT      2
`define PBT_RUN_BIT         1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PBT_RUN_RST         1'b0
`define PBT_IRQ_EN_RST      1'b0
`define PBT_FLAG_RST        1'b0
`define PBT_RATE_RST        3'h0
`define PBT_RDATA_RST       8'h00

// ----------------------------------------------------------------------------
// divider chain and timing
// ----------------------------------------------------------------------------
`define PBT_CHAIN_W         15
`define PBT_XTAL_HZ         32768
`define PBT_MCLK_HZ         200000000
// crystal period in system clocks, rounded down; the edge detector needs at least 4
`define PBT_XTAL_CYC        (`PBT_MCLK_HZ / `PBT_XTAL_HZ)

`endif

// ===== shared/pbt_pkg.sv
// types shared by the periodic timebase modules
package pbt_pkg;

    // ------------------------------------------------------------------------
    // rate selection codes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        PBT_DIV_32768 = 3'b000,
        PBT_DIV_8192  = 3'b001,
        PBT_DIV_2048  = 3'b010,
        PBT_DIV_128   = 3'b011,
        PBT_DIV_64    = 3'b100,
        PBT_DIV_32    = 3'b101,
        PBT_DIV_16    = 3'b110,
        PBT_DIV_8     = 3'b111
    } pbt_rate_e;

    typedef logic [14:0] pbt_chain_t;
    typedef logic [3:0]  pbt_tap_t;

    // ------------------------------------------------------------------------
    // module state records
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       run;
        logic       irq_en;
        pbt_rate_e  rate;
        logic       flag;
        logic       irq;
        logic       wake;
        logic [7:0] rdata;
    } pbt_ctrl_s;

    typedef struct packed {
        logic [1:0] sync;
        logic       last;
        logic       tick;
    } pbt_sync_s;

    typedef struct packed {
        pbt_chain_t count;
    } pbt_chain_s;

endpackage

// ===== shared/pbt_chain_if.sv
// carries the crystal tick and the divider chain controls between timebase modules
interface pbt_chain_if;
    import pbt_pkg::*;

    logic       xtal_tick;
    logic       advance;
    logic       clear;
    pbt_chain_t count;

    modport sync_m (
        output xtal_tick
    );

    modport chain_m (
        input  advance,
        input  clear,
        output count
    );

    modport ctrl_m (
        input  xtal_tick,
        input  count,
        output advance,
        output clear
    );
endinterface

// ===== logic/pbt_xtal_sync.sv
// two-stage synchroniser and rising-edge detector for the crystal clock pin
module pbt_xtal_sync
    import pbt_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic crystal_input_i,
    pbt_chain_if.sync_m chain
);

    pbt_sync_s st_q;
    pbt_sync_s st_d;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.sync[0] = crystal_input_i;
        st_d.sync[1] = st_q.sync[0];
        st_d.last    = st_q.sync[1];
        // the edge is taken only from the second stage, never the first
        st_d.tick    = st_q.sync[1] & ~st_q.last;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign chain.xtal_tick = st_q.tick;

endmodule

// ===== logic/pbt_chain.sv
// fifteen-stage divider chain clocked by crystal ticks
module pbt_chain
    import pbt_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    pbt_chain_if.chain_m chain
);

    pbt_chain_s st_q;
    pbt_chain_s st_d;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (chain.clear) begin
            st_d.count = '0;
        end else if (chain.advance) begin
            st_d.count = st_q.count + pbt_chain_t'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign chain.count = st_q.count;

endmodule

// ===== logic/pbt_timebase.sv
// periodic timebase: control register, rate tap select, rollover flag and interrupt
//
// Chosen here: the address map and strobed register access.
`include "pbt_cfg.svh"
module pbt_timebase
    import pbt_pkg::*;
(
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [`PBT_ADDR_W-1:0] reg_addr_i,
    input  wire logic [`PBT_DATA_W-1:0] reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [`PBT_DATA_W-1:0] reg_rdata_o,
    input  wire logic                   crystal_input_i,
    input  wire logic                   wait_mode_i,
    input  wire logic                   stop_mode_i,
    input  wire logic                   osc_run_in_stop_i,
    output logic                        rollover_irq_o,
    output logic                        stop_wakeup_o,
    output logic                        timebase_active_o
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    pbt_ctrl_s  st_q;
    pbt_ctrl_s  st_d;

    pbt_chain_if chain ();

    logic       osc_alive;
    logic       bus_open;
    logic       hit_ctrl;
    logic       wr_ctrl;
    logic       rd_ctrl;
    logic       rollover;
    logic       ack_req;
    pbt_tap_t   tap_idx;
    pbt_chain_t tap_mask;
    pbt_chain_t tap_bit;

    // ------------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------------
    pbt_xtal_sync u_sync (
        .mclk_i          (mclk_i),
        .rst_n_i         (rst_n_i),
        .crystal_input_i (crystal_input_i),
        .chain           (chain.sync_m)
    );

    pbt_chain u_chain (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .chain   (chain.chain_m)
    );

    // ------------------------------------------------------------------------
    // tap selection
    // ------------------------------------------------------------------------
    // the flag is raised when the chosen chain bit rises; a bit of weight d/2
    // first rises d/2 ticks after clearing and then every d ticks
    function automatic pbt_tap_t tap_of(input pbt_rate_e rate);
        pbt_tap_t idx;
        idx = 4'h0;
        unique case (rate)
            PBT_DIV_32768: idx = 4'he;
            PBT_DIV_8192:  idx = 4'hc;
            PBT_DIV_2048:  idx = 4'ha;
            PBT_DIV_128:   idx = 4'h6;
            PBT_DIV_64:    idx = 4'h5;
            PBT_DIV_32:    idx = 4'h4;
            PBT_DIV_16:    idx = 4'h3;
            PBT_DIV_8:     idx = 4'h2;
        endcase
        return idx;
    endfunction

    assign tap_idx  = tap_of(st_q.rate);
    assign tap_bit  = pbt_chain_t'(1) << tap_idx;
    assign tap_mask = tap_bit - pbt_chain_t'(1);

    // tap bit rises on this advance
    assign rollover = chain.advance
                    & ((chain.count & tap_bit) == '0)
                    & ((chain.count & tap_mask) == tap_mask);

    // ------------------------------------------------------------------------
    // low power gating
    // ------------------------------------------------------------------------
    // oscillator stalls in stop unless allowed
    assign osc_alive = ~stop_mode_i | osc_run_in_stop_i;

    assign bus_open  = ~wait_mode_i & ~stop_mode_i;

    assign chain.advance = chain.xtal_tick & st_q.run & osc_alive;
    assign chain.clear   = ~st_q.run;

    // ------------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------------
    // unmapped addresses read zero and swallow writes
    assign hit_ctrl = (reg_addr_i == `PBT_CTRL_OFS);
    assign wr_ctrl  = reg_wr_i & hit_ctrl & bus_open;
    assign rd_ctrl  = reg_rd_i & hit_ctrl & bus_open;
    assign ack_req  = wr_ctrl & reg_wdata_i[`PBT_ACK_BIT];

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_d       = st_q;
        st_d.rdata = `PBT_RDATA_RST;

        if (wr_ctrl) begin
            st_d.run    = reg_wdata_i[`PBT_RUN_BIT];
            st_d.irq_en = reg_wdata_i[`PBT_IRQ_EN_BIT];
            // rate changes while running are taken as written; software keeps
            // rate fixed while running
            st_d.rate   = pbt_rate_e'(reg_wdata_i[`PBT_RATE_MSB:`PBT_RATE_LSB]);
        end

        if (ack_req) begin
            st_d.flag = 1'b0;
        end
        // rollover sets flag, winning over a same-cycle acknowledge
        if (rollover) begin
            st_d.flag = 1'b1;
        end

        st_d.irq  = st_d.flag & st_d.irq_en;
        st_d.wake = st_d.irq & stop_mode_i & osc_alive;

        if (rd_ctrl) begin
            st_d.rdata[`PBT_FLAG_BIT]                 = st_q.flag;
            st_d.rdata[`PBT_RATE_MSB:`PBT_RATE_LSB]   = st_q.rate;
            st_d.rdata[`PBT_ACK_BIT]                  = 1'b0;
            st_d.rdata[`PBT_IRQ_EN_BIT]               = st_q.irq_en;
            st_d.rdata[`PBT_RUN_BIT]                  = st_q.run;
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_q.run    <= `PBT_RUN_RST;
            st_q.irq_en <= `PBT_IRQ_EN_RST;
            st_q.rate   <= pbt_rate_e'(`PBT_RATE_RST);
            st_q.flag   <= `PBT_FLAG_RST;
            st_q.irq    <= 1'b0;
            st_q.wake   <= 1'b0;
            st_q.rdata  <= `PBT_RDATA_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign reg_rdata_o       = st_q.rdata;
    assign rollover_irq_o    = st_q.irq;
    assign stop_wakeup_o     = st_q.wake;
    assign timebase_active_o = st_q.run & osc_alive;

endmodule

// ===== tb/pbt_timebase_chk.sv
// port assertions for the periodic timebase
`include "pbt_cfg.svh"
module pbt_timebase_chk (
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       crystal_input_i,
    input wire logic       wait_mode_i,
    input wire logic       stop_mode_i,
    input wire logic       osc_run_in_stop_i,
    input wire logic       rollover_irq_o,
    input wire logic       stop_wakeup_o,
    input wire logic       timebase_active_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------
    // helpers
    // ------
    // pin history: a tick lands a few cycles after a rise, so acks near one are skipped
    logic [7:0] xh_q;
    logic [6:0] rise;
    logic       ctl_wr;
    always_ff @(posedge mclk_i) xh_q <= {xh_q[6:0], crystal_input_i};
    assign rise   = xh_q[6:0] & ~xh_q[7:1];
    assign ctl_wr = reg_wr_i && reg_addr_i == `PBT_CTRL_OFS && !wait_mode_i && !stop_mode_i;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_ack;
        ctl_wr && reg_wdata_i[`PBT_ACK_BIT] && rise[4:0] == 5'h00;
    endsequence
    sequence s_refused_rd;
        reg_rd_i && (wait_mode_i || stop_mode_i || reg_addr_i != `PBT_CTRL_OFS);
    endsequence
    // ------
    // assertions
    // ------
    AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside a read slot");
    AST_ACK_RD0: assert property (reg_rd_i |=> !reg_rdata_o[`PBT_ACK_BIT] && !reg_rdata_o[0])
        else $error("acknowledge or reserved bit read as one");
    AST_RD_REFUSE: assert property (s_refused_rd |=> reg_rdata_o == 8'h00)
        else $error("refused read returned data");
    AST_ACK_CLR: assert property (s_ack |=> !rollover_irq_o)
        else $error("acknowledge left interrupt set");
    AST_IRQ_HOLD: assert property (rollover_irq_o && !ctl_wr |=> rollover_irq_o)
        else $error("interrupt dropped without acknowledge");
    AST_IRQ_CAUSE: assert property ($rose(rollover_irq_o) |-> (|rise) || $past(ctl_wr))
        else $error("interrupt rose without tick or write");
    AST_STOP_OFF: assert property (stop_mode_i && !osc_run_in_stop_i |-> !timebase_active_o)
        else $error("active in stop without oscillator");
    AST_WAKE: assert property (rollover_irq_o && stop_mode_i && osc_run_in_stop_i |=> stop_wakeup_o)
        else $error("no wakeup from interrupt in stop");
endmodule

bind pbt_timebase pbt_timebase_chk i_pbt_timebase_chk (.*);

// ===== tb/tb_top.sv
// self-checking bench for the periodic timebase
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %0h, expected %0h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk        = 1'b0;
    logic       rst_n      = 1'b0;
    logic [7:0] addr       = 8'h00;
    logic [7:0] wdata      = 8'h00;
    logic       wr_s       = 1'b0;
    logic       rd_s       = 1'b0;
    logic       xtal       = 1'b0;
    logic       wt         = 1'b0;
    logic       stp        = 1'b0;
    logic       osc        = 1'b0;
    logic       xon        = 1'b0;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    logic       act;
    int         cyc        = 0;
    int         rises      = 0;
    int         num_errors = 0;
    int         num_checks = 0;
    int         dv[8]      = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

    always #2.5 clk = ~clk;

    pbt_timebase i_pbt_timebase (
        .mclk_i            (clk),
        .rst_n_i           (rst_n),
        .reg_addr_i        (addr),
        .reg_wdata_i       (wdata),
        .reg_wr_i          (wr_s),
        .reg_rd_i          (rd_s),
        .reg_rdata_o       (rdata),
        .crystal_input_i   (xtal),
        .wait_mode_i       (wt),
        .stop_mode_i       (stp),
        .osc_run_in_stop_i (osc),
        .rollover_irq_o    (irq),
        .stop_wakeup_o     (wake),
        .timebase_active_o (act)
    );

    // ------
    // crystal stand-in and timeout
    // ------
    // eight cycles a period, far faster than real, so long dividers stay short; frozen while xon is low
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (xon && cyc % 4 == 0) begin
            xtal <= ~xtal;
            if (!xtal) rises <= rises + 1;
        end
        if (cyc == 50000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------
    // bus and wait helpers
    // ------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        `CHK(rdata, e)
        @(posedge clk);
    endtask

    // returns the crystal rise count at the moment the interrupt shows
    task automatic wait_irq(output int n);
        int k = 0;
        while (irq !== 1'b1 && k < 30000) begin
            @(posedge clk);
            #1;
            k++;
        end
        `CHK(irq, 1'b1)
        n = rises;
        @(posedge clk);
    endtask

    // ------
    // scenarios
    // ------
    task automatic t_regs();
        rd(8'h00, 8'h00);
        `CHK(act, 1'b0)
        for (int r = 0; r < 8; r++) begin
            wr(8'h00, {1'b0, r[2:0], 4'b1001});
            rd(8'h00, {1'b0, r[2:0], 4'h0});
        end
        wr(8'h01, 8'h06);
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h70);
    endtask

    task automatic t_mask();
        wr(8'h00, 8'h72);
        `CHK(act, 1'b1)
        xon <= 1'b1;
        repeat (60) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(8'h00, 8'hf2);
        wr(8'h00, 8'h76);
        `CHK(irq, 1'b1)
    endtask

    task automatic t_lowpow();
        int n;
        wt <= 1'b1;
        wr(8'h00, 8'h7e);
        `CHK(irq, 1'b1)
        rd(8'h00, 8'h00);
        wt <= 1'b0;
        wr(8'h00, 8'h7e);
        `CHK(irq, 1'b0)
        wt <= 1'b1;
        wait_irq(n);
        `CHK(irq, 1'b1)
        wt <= 1'b0;
        wr(8'h00, 8'h7e);
        stp <= 1'b1;
        @(posedge clk);
        `CHK(act, 1'b0)
        repeat (100) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(8'h00, 8'h00);
        osc <= 1'b1;
        wait_irq(n);
        @(posedge clk);
        `CHK(wake, 1'b1)
        stp <= 1'b0;
        osc <= 1'b0;
        // run is dropped with the rate kept, so the rate never moves while running
        wr(8'h00, 8'h78);
        `CHK(act, 1'b0)
        stp <= 1'b1;
        osc <= 1'b1;
        @(posedge clk);
        `CHK(act, 1'b0)
        stp <= 1'b0;
        osc <= 1'b0;
    endtask

    // run off then on restarts the chain, so the first flag comes at half the period
    task automatic t_rate(input logic [2:0] r);
        logic [7:0] c;
        int         n0, n1, n2;
        c = {1'b0, r, 4'b0110};
        xon <= 1'b0;
        wr(8'h00, {1'b0, r, 4'h0});
        rd(8'h00, {1'b0, r, 4'h0});
        n0 = rises;
        wr(8'h00, c);
        xon <= 1'b1;
        wait_irq(n1);
        `CHK(n1 - n0, dv[r] / 2)
        rd(8'h00, c | 8'h80);
        wr(8'h00, c);
        `CHK(irq, 1'b1)
        wr(8'h00, c | 8'h08);
        `CHK(irq, 1'b0)
        wait_irq(n2);
        `CHK(n2 - n1, dv[r])
        // acknowledge and stop together; the next rate is then written while stopped
        wr(8'h00, {1'b0, r, 4'b1000});
    endtask

    // reset in mid-run clears flag, rate, enable and run
    task automatic t_reset();
        int n;
        wr(8'h00, 8'h70);
        wr(8'h00, 8'h76);
        wait_irq(n);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(irq, 1'b0)
        rd(8'h00, 8'h00);
        `CHK(act, 1'b0)
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_mask();
        t_lowpow();
        for (int r = 7; r >= 2; r--) begin
            t_rate(r[2:0]);
        end
        t_reset();
        end_of_test();
    end
endmodule
